// ---- core/smc_comparator.sv ----
// Operation
// - word is 42 pulse positions, one clock each
// - digits arrive least significant first
// - sign pulse means positive, none negative
// - flip-flop sets, restores, holds between pulses
// - set and restore outputs are complementary
// - gate passes with permissives, without inhibits
// - buffer merges sources as logical or
// - sign flag sets on pulse at p37
// - sign flag restored at p35 every word
// - positive sign holds flag 40 pulse times
// - sign read out through gate at p1
// - restoring pulse clears greater flag first
// - equal digits change no state
// - a one, b zero sets greater flag
// - b one, a zero restores greater flag
// - simple result is greater or not greater
// - restored full states give equal indication
// - a one, b zero sets a-greater state
// - b wins sets b-greater, restores a-greater
// - state after most significant digit is result
// - sign position suppressed at comparison gates
// - gate controls overlap the gated signal
`timescale 1ns/100ps
`include "smc_defines.svh"

module smc_comparator #(
  parameter int WORD_POSITIONS = `SMC_WORD_POSITIONS
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                word_start,
  input  wire logic                restore_pulse,
  input  wire smc_pkg::smc_digits_s digits,
  input  wire logic                sign_line,
  output logic                     simple_a_greater,
  output smc_pkg::smc_outcome_s    outcome,
  output logic                     sign_set_out,
  output logic                     sign_restore_out,
  output logic                     sign_readout,
  output smc_pkg::smc_timing_s     timing
);
  import smc_pkg::*;

  localparam logic [`SMC_POS_W-1:0] POS_LAST = `SMC_POS_W'(WORD_POSITIONS - 1);

  // position counter and its next value
  logic [`SMC_POS_W-1:0] pos_ff;
  logic [`SMC_POS_W-1:0] nxt_pos;
  // comparator flip-flops
  logic                  greater_ff;
  logic                  nxt_greater;
  logic                  a_greater_state_ff;
  logic                  nxt_a_greater_state;
  logic                  b_greater_state_ff;
  logic                  nxt_b_greater_state;
  // sign capture flip-flop, both sides registered
  logic                  sign_flag_ff;
  logic                  nxt_sign_flag;
  logic                  sign_restore_ff;
  // output registers
  logic                  readout_ff;
  smc_timing_s           timing_ff;
  smc_outcome_s          outcome_ff;
  logic                  simple_ff;

  // word position counter, word_start realigns to position 0
  assign nxt_pos = word_start ? `SMC_RST_POS :
                   (pos_ff == POS_LAST) ? `SMC_RST_POS : pos_ff + `SMC_POS_W'(1);

  // timing pulses decoded from the current position
  wire at_sign_clear = (pos_ff == `SMC_POS_SIGN_CLEAR);
  wire at_sign       = (pos_ff == `SMC_POS_SIGN);
  wire at_readout    = (pos_ff == `SMC_POS_READOUT);

  // comparison gates: each digit inhibits the other, sign suppressed
  wire a_wins_gate = digits.a_digit & ~digits.b_digit & ~at_sign;
  wire b_wins_gate = digits.b_digit & ~digits.a_digit & ~at_sign;

  // restore sources buffered together
  wire clear_greater = restore_pulse | b_wins_gate;

  // simple comparator flag, restore wins over a set
  assign nxt_greater = a_wins_gate & ~restore_pulse ? 1'b1 :
                       clear_greater ? 1'b0 : greater_ff;

  // full comparator states
  assign nxt_a_greater_state = restore_pulse ? 1'b0 :
                               a_wins_gate ? 1'b1 :
                               b_wins_gate ? 1'b0 : a_greater_state_ff;
  assign nxt_b_greater_state = restore_pulse ? 1'b0 :
                               b_wins_gate ? 1'b1 :
                               a_wins_gate ? 1'b0 : b_greater_state_ff;

  // sign capture gate and flag, set beats the clear
  wire sign_gate = sign_line & at_sign;
  assign nxt_sign_flag = sign_gate ? 1'b1 :
                         at_sign_clear ? 1'b0 : sign_flag_ff;

  // sequential state
  always_ff @(posedge clock) begin
    if (reset) begin
      pos_ff             <= `SMC_RST_POS;
      greater_ff         <= `SMC_RST_BIT;
      a_greater_state_ff <= `SMC_RST_BIT;
      b_greater_state_ff <= `SMC_RST_BIT;
      sign_flag_ff       <= `SMC_RST_BIT;
      sign_restore_ff    <= 1'b1;
    end else begin
      pos_ff             <= nxt_pos;
      greater_ff         <= nxt_greater;
      a_greater_state_ff <= nxt_a_greater_state;
      b_greater_state_ff <= nxt_b_greater_state;
      sign_flag_ff       <= nxt_sign_flag;
      sign_restore_ff    <= ~nxt_sign_flag;
    end
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      readout_ff <= `SMC_RST_BIT;
      timing_ff  <= '0;
      outcome_ff <= '{a_greater: 1'b0, equal: 1'b1, less_than: 1'b0};
      simple_ff  <= `SMC_RST_BIT;
    end else begin
      readout_ff <= sign_flag_ff & at_readout;
      timing_ff  <= '{sign_clear_pulse: at_sign_clear, sign_position_pulse: at_sign,
                      sign_readout_pulse: at_readout};
      outcome_ff <= '{a_greater: nxt_a_greater_state,
                      equal: ~nxt_a_greater_state & ~nxt_b_greater_state,
                      less_than: nxt_b_greater_state & ~nxt_a_greater_state};
      simple_ff  <= nxt_greater;
    end
  end

  assign simple_a_greater = simple_ff;
  assign outcome          = outcome_ff;
  assign sign_set_out     = sign_flag_ff;
  assign sign_restore_out = sign_restore_ff;
  assign sign_readout     = readout_ff;
  assign timing           = timing_ff;

  // helper count of cycles the sign flag stays set
  logic [`SMC_POS_W-1:0] held_cnt;
  always_ff @(posedge clock) begin
    if (reset) begin
      held_cnt <= `SMC_RST_POS;
    end else if (sign_flag_ff) begin
      held_cnt <= held_cnt + `SMC_POS_W'(1);
    end else begin
      held_cnt <= `SMC_RST_POS;
    end
  end

  // position wraps to 0 after the last position
  chk_pos_wraps: assert property (@(posedge clock) disable iff (reset)
    (pos_ff == POS_LAST && !word_start) |=> pos_ff == `SMC_RST_POS)
    else $error("position did not wrap after last");

  // position steps by one inside a word
  chk_pos_steps: assert property (@(posedge clock) disable iff (reset)
    (pos_ff != POS_LAST && !word_start) |=> pos_ff == $past(pos_ff) + `SMC_POS_W'(1))
    else $error("position did not step by one");

  // word_start realigns the counter
  chk_start_aligns: assert property (@(posedge clock) disable iff (reset)
    word_start |=> pos_ff == `SMC_RST_POS)
    else $error("word start did not realign position");

  // a win sets a-greater and restores b-greater
  chk_a_wins_sets: assert property (@(posedge clock) disable iff (reset)
    (a_wins_gate && !restore_pulse) |=> a_greater_state_ff && !b_greater_state_ff)
    else $error("a win did not set a-greater");

  // b win sets b-greater and restores a-greater
  chk_b_wins_sets: assert property (@(posedge clock) disable iff (reset)
    (b_wins_gate && !restore_pulse) |=> b_greater_state_ff && !a_greater_state_ff)
    else $error("b win did not set b-greater");

  // restore beats a digit in the same pulse time
  chk_restore_wins: assert property (@(posedge clock) disable iff (reset)
    restore_pulse |=> !a_greater_state_ff && !b_greater_state_ff && !greater_ff)
    else $error("restore lost to a digit");

  // matching digits leave every comparator flip-flop alone
  chk_equal_holds: assert property (@(posedge clock) disable iff (reset)
    (!a_wins_gate && !b_wins_gate && !restore_pulse) |=>
      $stable(greater_ff) && $stable(a_greater_state_ff) && $stable(b_greater_state_ff))
    else $error("state changed on equal digits");

  // restore shows equal on the next output cycle
  chk_restore_equal: assert property (@(posedge clock) disable iff (reset)
    restore_pulse |=> outcome.equal && !outcome.less_than && !outcome.a_greater)
    else $error("restore did not give equal");

  // equal persists while digits keep matching
  chk_equal_persists: assert property (@(posedge clock) disable iff (reset)
    (outcome.equal && !a_wins_gate && !b_wins_gate) |=> outcome.equal)
    else $error("equal dropped on matching digits");

  // exactly one indication at any time
  chk_one_outcome: assert property (@(posedge clock) disable iff (reset)
    $onehot(outcome))
    else $error("outcome not one-hot");

  // outcome shows the state flip-flops
  chk_outcome_tracks: assert property (@(posedge clock) disable iff (reset)
    outcome.a_greater == a_greater_state_ff && outcome.less_than == b_greater_state_ff)
    else $error("outcome does not show comparator state");

  // simple comparator set by an a win
  chk_simple_set: assert property (@(posedge clock) disable iff (reset)
    (a_wins_gate && !restore_pulse) |=> greater_ff)
    else $error("a win did not set simple flag");

  // simple comparator restored by a b win
  chk_simple_restore: assert property (@(posedge clock) disable iff (reset)
    b_wins_gate |=> !greater_ff)
    else $error("b win did not restore simple flag");

  // simple output shows only greater or not greater
  chk_simple_out: assert property (@(posedge clock) disable iff (reset)
    simple_a_greater == greater_ff)
    else $error("simple output differs from its flag");

  // restoring pulse clears the simple flag
  chk_simple_clear: assert property (@(posedge clock) disable iff (reset)
    restore_pulse |=> !greater_ff)
    else $error("restore did not clear greater");

  // buffered restore sources each clear the flag
  chk_buffer_or: assert property (@(posedge clock) disable iff (reset)
    (restore_pulse || b_wins_gate) |=> !greater_ff)
    else $error("buffered restore source ignored");

  // both digits high block both gates
  chk_gate_blocked: assert property (@(posedge clock) disable iff (reset)
    (digits.a_digit && digits.b_digit) |-> !a_wins_gate && !b_wins_gate)
    else $error("gate passed with inhibit present");

  // sign position takes no part in the decision
  chk_sign_ignored: assert property (@(posedge clock) disable iff (reset)
    (at_sign && !restore_pulse) |=>
      $stable(a_greater_state_ff) && $stable(b_greater_state_ff) && $stable(greater_ff))
    else $error("sign position altered comparison");

  // sign pulse at the sample sets the flag
  chk_sign_capture: assert property (@(posedge clock) disable iff (reset)
    (at_sign && sign_line) |=> sign_set_out && !sign_restore_out)
    else $error("sign not captured");

  // no sign pulse leaves the flag restored
  chk_sign_negative: assert property (@(posedge clock) disable iff (reset)
    (at_sign && !sign_line && $past(at_sign_clear, 2)) |=> !sign_set_out)
    else $error("negative word set sign flag");

  // set and restore sides always opposite
  chk_sign_complement: assert property (@(posedge clock) disable iff (reset)
    sign_set_out != sign_restore_out)
    else $error("sign outputs not complementary");

  // flag holds between set and restore pulses
  chk_sign_holds: assert property (@(posedge clock) disable iff (reset)
    (!sign_gate && !at_sign_clear) |=> $stable(sign_flag_ff))
    else $error("sign flag changed without a pulse");

  // clear pulse restores the flag
  chk_sign_clear: assert property (@(posedge clock) disable iff (reset)
    at_sign_clear |=> !sign_set_out)
    else $error("sign flag not cleared");

  // a captured sign stays no longer than the held count
  chk_sign_held: assert property (@(posedge clock) disable iff (reset)
    held_cnt <= `SMC_POS_W'(`SMC_SIGN_HELD_TIMES))
    else $error("sign held too long");

  // sign timing pulse follows its position
  chk_timing_sign: assert property (@(posedge clock) disable iff (reset)
    at_sign |=> timing.sign_position_pulse)
    else $error("sign timing pulse missing");

  // clear timing pulse follows its position
  chk_timing_clear: assert property (@(posedge clock) disable iff (reset)
    at_sign_clear |=> timing.sign_clear_pulse)
    else $error("clear timing pulse missing");

  // readout gate passes a captured sign
  chk_readout_gate: assert property (@(posedge clock) disable iff (reset)
    (at_readout && sign_flag_ff) |=> sign_readout)
    else $error("readout missed");

  // readout gate blocked otherwise
  chk_readout_quiet: assert property (@(posedge clock) disable iff (reset)
    (!at_readout || !sign_flag_ff) |=> !sign_readout)
    else $error("readout without strobe or sign");

  // readout timing pulse follows its position
  chk_timing_readout: assert property (@(posedge clock) disable iff (reset)
    at_readout |=> timing.sign_readout_pulse)
    else $error("readout timing pulse missing");

  // main scenarios
  cov_a_wins: cover property (@(posedge clock) disable iff (reset) outcome.a_greater);
  cov_b_wins: cover property (@(posedge clock) disable iff (reset) outcome.less_than);
  cov_sign_full: cover property (@(posedge clock) disable iff (reset)
    held_cnt == `SMC_POS_W'(`SMC_SIGN_HELD_TIMES));
  cov_readout: cover property (@(posedge clock) disable iff (reset) sign_readout);
  cov_late_win: cover property (@(posedge clock) disable iff (reset) a_greater_state_ff ##1 b_greater_state_ff);

endmodule

// ---- core/smc_defines.svh ----
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// word structure in pulse positions
`define SMC_WORD_POSITIONS   42
`define SMC_POS_W            6
`define SMC_POS_LAST         6'h29
`define SMC_POS_SIGN_CLEAR   6'h23
`define SMC_POS_SIGN         6'h25
`define SMC_POS_READOUT      6'h01
`define SMC_SIGN_HELD_TIMES  40

// reset values
`define SMC_RST_POS          6'h00
`define SMC_RST_BIT          1'b0

`endif

// ---- core/smc_pkg.sv ----
package smc_pkg;

  // one pulse time of both operand lines
  typedef struct packed {
    logic a_digit;
    logic b_digit;
  } smc_digits_s;

  // outcome of the full comparator
  typedef struct packed {
    logic a_greater;
    logic equal;
    logic less_than;
  } smc_outcome_s;

  // timing pulses decoded from the word position
  typedef struct packed {
    logic sign_clear_pulse;
    logic sign_position_pulse;
    logic sign_readout_pulse;
  } smc_timing_s;

endpackage

// ---- sim/smc_word_source.sv ----
`timescale 1ns/100ps
// upstream source: sends one 42-position word per go request
module smc_word_source (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 go,
  input  wire logic [29:0]          a_word,
  input  wire logic [29:0]          b_word,
  input  wire logic                 positive,
  output logic                      word_start,
  output logic                      restore_pulse,
  output smc_pkg::smc_digits_s      digits,
  output logic                      sign_line,
  output logic                      busy_ff,
  output logic [5:0]                pos_ff
);
  import smc_pkg::*;
  logic started_ff;
  initial begin
    {word_start, restore_pulse, digits, sign_line, busy_ff, pos_ff, started_ff} = '0;
  end
  // lines change at the falling edge so each value spans a whole pulse time
  // first word aligns with word_start, later ones follow the free-running wrap
  always @(negedge clock) begin
    word_start <= !reset && !started_ff && go;
    restore_pulse <= !reset && busy_ff && (pos_ff == 6'h06);
    sign_line <= !reset && busy_ff && (pos_ff == 6'h25) && positive;
    if (!reset && busy_ff && pos_ff >= 6'h07 && pos_ff <= 6'h24) begin
      digits <= {a_word[pos_ff-6'h07], b_word[pos_ff-6'h07]};
    end else if (!reset && busy_ff && pos_ff == 6'h25) begin
      digits <= {positive, 1'b0}; // sign also on a, must be suppressed
    end else begin
      digits <= '0; // gap positions never carry pulses
    end
    if (reset) begin
      started_ff <= 1'b0;
      busy_ff <= 1'b0;
      pos_ff <= 6'h00;
    end else if (!started_ff) begin
      started_ff <= go;
      busy_ff <= go;
      pos_ff <= 6'h00;
    end else begin
      pos_ff <= (pos_ff == 6'h29) ? 6'h00 : pos_ff + 6'h01;
      if (pos_ff == 6'h29) busy_ff <= go;
    end
  end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import smc_pkg::*;
  typedef struct packed {
    logic [29:0] a;
    logic [29:0] b;
    logic        pos;
    logic [2:0]  res;
    logic        simp;
  } smc_row_s;
  logic clock = 1'b0, reset = 1'b1, go = 1'b0, positive = 1'b0;
  logic [29:0] a_word = '0, b_word = '0;
  logic word_start, restore_pulse, sign_line, busy_ff, simple_a_greater, sign_set_out, sign_restore_out, sign_readout;
  logic [5:0] pos_ff;
  smc_digits_s digits;
  smc_outcome_s outcome;
  smc_timing_s timing;
  int n_mismatch = 0, checks = 0, cycles = 0, n_set = 0, n_ro = 0, n_tim = 0;
  smc_row_s rows [8] = '{'{30'h1B7, 30'h3A9, 1'b1, 3'h1, 1'b0}, '{30'h3A9, 30'h1B7, 1'b0, 3'h4, 1'b1},
    '{30'h2AAAAAAA, 30'h2AAAAAAA, 1'b1, 3'h2, 1'b0}, '{30'h3FFFFFFF, 30'h0, 1'b1, 3'h4, 1'b1},
    '{30'h1, 30'h0, 1'b0, 3'h4, 1'b1}, '{30'h20000000, 30'h1FFFFFFF, 1'b0, 3'h4, 1'b1},
    '{30'h0, 30'h20000000, 1'b1, 3'h1, 1'b0}, '{30'h0, 30'h0, 1'b1, 3'h2, 1'b0}};
  always #10 clock = ~clock;
  smc_word_source i_src (.clock(clock), .reset(reset), .go(go), .a_word(a_word), .b_word(b_word),
    .positive(positive),
    .word_start(word_start), .restore_pulse(restore_pulse), .digits(digits), .sign_line(sign_line),
    .busy_ff(busy_ff), .pos_ff(pos_ff));
  smc_comparator i_dut (.clock(clock), .reset(reset), .word_start(word_start), .restore_pulse(restore_pulse),
    .digits(digits), .sign_line(sign_line), .simple_a_greater(simple_a_greater), .outcome(outcome),
    .sign_set_out(sign_set_out), .sign_restore_out(sign_restore_out), .sign_readout(sign_readout),
    .timing(timing));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one word through the source, then the settled result
  task automatic send(input smc_row_s r);
    n_set = 0;
    n_ro = 0;
    n_tim = 0;
    a_word <= r.a;
    b_word <= r.b;
    positive <= r.pos;
    go <= 1'b1;
    @(negedge clock);
    while (busy_ff !== 1'b1) @(negedge clock);
    go <= 1'b0;
    while (busy_ff === 1'b1) @(negedge clock);
    check(outcome, r.res);
    check(simple_a_greater, r.simp);
    check({sign_set_out, sign_restore_out}, {r.pos, !r.pos});
    check(16'(n_set), 16'(4 * r.pos));
    check(16'(n_ro), 16'h0000);
    check(16'(n_tim), 16'h0003);
  endtask
  // per-word counts while the source is busy, plus hang guard
  always @(negedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      close_out();
    end
    if (busy_ff === 1'b1) begin
      n_set += (sign_set_out === 1'b1);
      n_ro += (sign_readout === 1'b1);
      n_tim += (timing.sign_clear_pulse === 1'b1) + (timing.sign_position_pulse === 1'b1);
      n_tim += (timing.sign_readout_pulse === 1'b1);
    end
  end
  initial begin
    repeat (3) @(negedge clock);
    reset <= 1'b0;
    @(negedge clock);
    foreach (rows[i]) send(rows[i]);
    // last positive sign read out at position 1 of the next word time
    repeat (2) @(negedge clock);
    check(sign_readout, 1'b1);
    check(timing, 3'h1);
    @(negedge clock);
    check(sign_readout, 1'b0);
    // reset in mid-run with the sign flag set
    reset <= 1'b1;
    repeat (3) @(negedge clock);
    check({simple_a_greater, outcome, sign_set_out, sign_restore_out, sign_readout, timing}, 16'h0090);
    reset <= 1'b0;
    @(negedge clock);
    send(rows[3]);
    close_out();
  end
endmodule
